// ---- verilog/fbp_flash_prot.v ----
`timescale 1ns/10ps
`include "fbp_regs.vh"

// flash array with per-unit read-only / execute-only protection
// limitation: contents are not reset, so erase a block before reading it
module fbp_flash_prot
(
	input  wire                   ref_clk,   // system clock
	input  wire                   rst,       // sync reset, high
	input  wire                   req,       // request strobe
	input  wire [2:0]             op,        // request kind
	input  wire [`FBP_ADDR_W-1:0] addr,      // word address
	input  wire [`FBP_WORD_W-1:0] wdata,     // program data
	input  wire [`FBP_UNITS-1:0]  ro_mark,   // read-only per unit
	input  wire [`FBP_UNITS-1:0]  xo_mark,   // execute-only per unit
	output wire                   ready,     // request may be taken
	output wire [`FBP_WORD_W-1:0] rdata,     // read data
	output wire                   rvalid,    // read answer pulse
	output wire                   denied,    // refused request pulse
	output wire                   wdone      // program/erase done pulse
);
	reg  [`FBP_WORD_W-1:0] mem [0:`FBP_WORDS-1];
	// marks after their two-flop synchronisers, one bit per unit
	wire [`FBP_UNITS-1:0]  ro_sync;
	wire [`FBP_UNITS-1:0]  xo_sync;
	// answer registers and their next values
	reg  [`FBP_WORD_W-1:0] rdata_q;
	reg  [`FBP_WORD_W-1:0] rdata_d;
	reg                    rvalid_q;
	reg                    rvalid_d;
	reg                    denied_q;
	reg                    denied_d;
	reg                    wdone_q;
	reg                    wdone_d;
	// decoded request
	wire [`FBP_UNIT_W-1:0] unit;
	wire                   unit_ro;
	wire                   unit_xo;
	wire                   do_prog;
	// marks come up open after reset
	localparam [`FBP_UNITS-1:0] prot_rst = `FBP_PROT_RST;
	genvar                 g;
	wire                   er_busy;
	wire                   er_wr;
	wire [`FBP_ADDR_W-1:0] er_addr;
	wire                   er_done;
	wire                   take;
	wire                   allow;
	wire                   is_rd;
	wire                   start_er;

	// unit index from word address; two blocks per unit
	function [`FBP_UNIT_W-1:0] unit_of;
		input [`FBP_ADDR_W-1:0] a;
		begin
			unit_of = a[`FBP_ADDR_W-1:`FBP_UNIT_LSB];
		end
	endfunction

	// permission check for one request
	function perm;
		input [2:0] o;
		input       ro;
		input       xo;
		begin
			case (o)
				`FBP_OP_FETCH: perm = 1'b1;
				`FBP_OP_DREAD: perm = !xo;
				`FBP_OP_DBGRD: perm = !xo;
				`FBP_OP_PROG:  perm = !ro && !xo;
				`FBP_OP_ERASE: perm = !ro && !xo;
				default:       perm = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// request kind decoding
	// ----------------------------------------------------------------
	// read kinds share one decoder so gating and answers agree
	function is_read;
		input [2:0] o;
		begin
			is_read = (o == `FBP_OP_FETCH) || (o == `FBP_OP_DREAD) || (o == `FBP_OP_DBGRD);
		end
	endfunction

	// program decode, used by the array and by the done pulse
	function is_prog;
		input [2:0] o;
		begin
			is_prog = (o == `FBP_OP_PROG);
		end
	endfunction

	// erase decode, used to start the sequencer
	function is_erase;
		input [2:0] o;
		begin
			is_erase = (o == `FBP_OP_ERASE);
		end
	endfunction

	// ----------------------------------------------------------------
	// protection marks: pins, so two flops before any logic reads them
	// ----------------------------------------------------------------
	// a mark change takes effect two edges later; change marks only
	// while no request to the affected unit is about to be taken
	generate
		for (g = 0; g < `FBP_UNITS; g = g + 1)
		begin : g_mark_sync
			reg ro_meta_q;
			reg xo_meta_q;
			reg ro_q;
			reg xo_q;

			// first stage feeds only the second
			always @(posedge ref_clk)
			begin
				if (rst)
				begin
					ro_meta_q <= prot_rst[g];
					xo_meta_q <= prot_rst[g];
					ro_q      <= prot_rst[g];
					xo_q      <= prot_rst[g];
				end
				else
				begin
					ro_meta_q <= ro_mark[g];
					xo_meta_q <= xo_mark[g];
					ro_q      <= ro_meta_q;
					xo_q      <= xo_meta_q;
				end
			end

			// each unit carries its own pair of marks
			assign ro_sync[g] = ro_q;
			assign xo_sync[g] = xo_q;
		end
	endgenerate

	// ----------------------------------------------------------------
	// request gating
	// ----------------------------------------------------------------
	// no marking means all five request kinds allowed; other op codes are refused
	assign ready    = !er_busy;
	assign take     = req && ready;
	assign unit     = unit_of(addr);
	assign unit_ro  = ro_sync[unit];
	assign unit_xo  = xo_sync[unit];
	assign allow    = perm(op, unit_ro, unit_xo);
	assign is_rd    = is_read(op);
	assign start_er = take && allow && is_erase(op);
	assign do_prog  = take && allow && is_prog(op);

	// ----------------------------------------------------------------
	// block erase sequencer
	// ----------------------------------------------------------------
	fbp_erase_seq u_erase
	(
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (start_er),
		.blk     (addr[`FBP_ADDR_W-1:`FBP_BLK_LSB]),
		.busy    (er_busy),
		.wr_en   (er_wr),
		.wr_addr (er_addr),
		.done    (er_done)
	);

	// ----------------------------------------------------------------
	// array writes; refused requests never reach the array
	// ----------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		if (er_wr)
			mem[er_addr] <= `FBP_ERASED;
		else if (do_prog)
			mem[addr] <= mem[addr] & wdata;        // flash bits only clear
	end

	// ----------------------------------------------------------------
	// answers: a read is returned the edge it is taken
	// ----------------------------------------------------------------
	// next answer values; a refused request never reads the array
	always @*
	begin
		rvalid_d = take && is_rd && allow;
		denied_d = take && !allow;
		wdone_d  = er_done || do_prog;
		rdata_d  = rdata_q;
		// blocked reads return zero rather than stale data
		if (take && is_rd)
			rdata_d = allow ? mem[addr] : {`FBP_WORD_W{1'b0}};
	end

	// answer registers: one-cycle pulses, read data held to the next read
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			rdata_q  <= {`FBP_WORD_W{1'b0}};
			rvalid_q <= 1'b0;
			denied_q <= 1'b0;
			wdone_q  <= 1'b0;
		end
		else
		begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
			denied_q <= denied_d;
			wdone_q  <= wdone_d;
		end
	end

	// outputs straight from flip-flops, so no decode glitch reaches them
	assign rdata  = rdata_q;
	assign rvalid = rvalid_q;
	assign denied = denied_q;
	assign wdone  = wdone_q;
endmodule

// ---- include/fbp_regs.vh ----
`ifndef FBP_REGS_VH
`define FBP_REGS_VH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define FBP_WORD_W      32
`define FBP_ADDR_W      14
`define FBP_WORDS       16384
`define FBP_BLK_LSB     8
`define FBP_BLK_W       6
`define FBP_BLK_WORDS   256
`define FBP_UNIT_LSB    9
`define FBP_UNIT_W      5
`define FBP_UNITS       32
`define FBP_ERASED      32'hffffffff

// ----------------------------------------------------------------
// request kinds and mark reset value
// ----------------------------------------------------------------
`define FBP_OP_FETCH    3'h0
`define FBP_OP_DREAD    3'h1
`define FBP_OP_DBGRD    3'h2
`define FBP_OP_PROG     3'h3
`define FBP_OP_ERASE    3'h4
`define FBP_PROT_RST    32'h00000000

`endif

// ---- verilog/fbp_erase_seq.v ----
`timescale 1ns/10ps
`include "fbp_regs.vh"

// walks the 256 words of one block, one word per clock
module fbp_erase_seq
(
	input  wire                  ref_clk,  // system clock
	input  wire                  rst,      // sync reset, high
	input  wire                  start,    // begin erase pulse
	input  wire [`FBP_BLK_W-1:0] blk,      // block to erase
	output wire                  busy,     // erase in progress
	output wire                  wr_en,    // word write strobe
	output wire [`FBP_ADDR_W-1:0] wr_addr, // word being erased
	output wire                  done      // last word pulse
);
	reg                   busy_q;
	reg [`FBP_ADDR_W-1:0] addr_q;

	// ----------------------------------------------------------------
	// word counter
	// ----------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			busy_q <= 1'b0;
			addr_q <= {`FBP_ADDR_W{1'b0}};
		end
		else if (!busy_q && start)
		begin
			busy_q <= 1'b1;
			addr_q <= {blk, {`FBP_BLK_LSB{1'b0}}};
		end
		else if (busy_q)
		begin
			addr_q <= addr_q + 1'b1;
			if (addr_q[`FBP_BLK_LSB-1:0] == {`FBP_BLK_LSB{1'b1}})
				busy_q <= 1'b0;
		end
	end

	// stays within the block: busy and wr_en fall after its last word
	assign busy    = busy_q;
	assign wr_en   = busy_q;
	assign wr_addr = addr_q;
	assign done    = busy_q && (addr_q[`FBP_BLK_LSB-1:0] == {`FBP_BLK_LSB{1'b1}});
endmodule

// ---- verification/fbp_asserts.sv ----
`timescale 1ns/10ps
// watches the top ports only
module fbp_asserts
(
	input wire        ref_clk, // clock
	input wire        rst,     // sync reset
	input wire        req,     // request
	input wire [2:0]  op,      // kind
	input wire [13:0] addr,    // word address
	input wire [31:0] ro_mark, // read-only marks
	input wire [31:0] xo_mark, // execute-only marks
	input wire        ready,   // accept
	input wire        rvalid,  // read pulse
	input wire        denied,  // refusal pulse
	input wire        wdone    // write done
);
	reg  [63:0] mk_q;
	reg  [63:0] mk2_q;
	// marks act two edges late, so judge only settled marks
	always @(posedge ref_clk)
	begin
		mk_q  <= {ro_mark, xo_mark};
		mk2_q <= mk_q;
	end
	wire st = (mk_q == {ro_mark, xo_mark}) && (mk2_q == mk_q);
	wire tk = req & ready;
	wire ro = ro_mark[addr[13:9]];
	wire xo = xo_mark[addr[13:9]];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	rd_one_cyc_a: assert property (tk && op < 3'h3 |=> rvalid ^ denied)
		else $error("read not answered next cycle");
	rd_cause_a: assert property (rvalid |-> $past(tk && op < 3'h3))
		else $error("read answer without request");
	xo_data_a: assert property (tk && st && xo && op == 3'h1 |=> denied)
		else $error("data read of execute-only unit");
	xo_dbg_a: assert property (tk && st && xo && op == 3'h2 |=> denied)
		else $error("debug read of execute-only unit");
	xo_fetch_a: assert property (tk && st && xo && op == 3'h0 |=> rvalid)
		else $error("fetch of execute-only unit refused");
	ro_write_a: assert property (tk && st && (ro | xo) && (op == 3'h3 || op == 3'h4) |=> denied && !wdone)
		else $error("write to protected unit");
	free_prog_a: assert property (tk && st && !ro && !xo && op == 3'h3 |=> wdone)
		else $error("program of open unit failed");
	erase_len_a: assert property (tk && st && !ro && !xo && op == 3'h4 |=> !ready[*8] ##249 wdone)
		else $error("erase length wrong");
endmodule

// ---- verification/fbp_req_model.sv ----
`timescale 1ns/10ps
// processor or debugger side: one request held until taken
module fbp_req_model
(
	input wire        ref_clk, // clock
	input wire        ready,   // design accepts
	output reg        req,     // request
	output reg [2:0]  op,      // kind
	output reg [13:0] addr,    // address
	output reg [31:0] wdata    // program data
);
	initial
	begin
		{req, op, addr, wdata} = 50'h0;
	end
	// released address and data lines show inverted values; op keeps its last value
	task issue(input [2:0] o, input [13:0] a, input [31:0] d);
	begin
		@(posedge ref_clk);
		{req, op, addr, wdata} <= {1'b1, o, a, d};
		@(negedge ref_clk);
		while (!ready) @(negedge ref_clk);
		@(posedge ref_clk);
		{req, addr, wdata} <= {1'b0, ~a, ~d};
	end
	endtask
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
`include "fbp_regs.vh"
module testbench;
	reg         ref_clk = 0;
	reg         rst = 1;
	reg  [31:0] ro_mark = 0, xo_mark = 0, d, e;
	wire        req, ready, rvalid, denied, wdone;
	wire [2:0]  op;
	wire [13:0] addr;
	wire [31:0] wdata, rdata;
	integer     error_cnt = 0, comparisons = 0, seed = 40834, cyc = 0;
	reg  [34:0] q[$];
	localparam [34:0] RD = 35'h400000000, DN = 35'h200000000, WD = 35'h100000000;
	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end
	fbp_req_model m_i (.ref_clk, .ready, .req, .op, .addr, .wdata);
	fbp_flash_prot fbp_flash_prot_i (.ref_clk, .rst, .req, .op, .addr, .wdata, .ro_mark,
		.xo_mark, .ready, .rdata, .rvalid, .denied, .wdone);
	task chk(input [34:0] s, input [34:0] x);
	begin
		comparisons = comparisons + 1;
		if (s !== x)
		begin
			error_cnt = error_cnt + 1;
			$display("MISMATCH %0t seen %h want %h", $time, s, x);
		end
	end
	endtask
	task finish_test;
	begin
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	task run(input [2:0] o, input [13:0] a, input [31:0] v, input [34:0] x);
	begin
		q.push_back(x);
		m_i.issue(o, a, v);
	end
	endtask
	// marks cross a two-flop synchroniser before they act
	task marks(input [31:0] r, input [31:0] x);
	begin
		ro_mark <= r;
		xo_mark <= x;
		repeat (2) @(posedge ref_clk);
	end
	endtask
	// answers are matched in order; rdata only counts on a read answer
	always @(posedge ref_clk)
		if (!rst && (rvalid | denied | wdone))
			chk({rvalid, denied, wdone, rvalid ? rdata : 32'h0}, q.size() ? q.pop_front() : 35'h0);
	always @(posedge ref_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 6000)
		begin
			error_cnt = error_cnt + 1;
			finish_test;
		end
	end
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		d = $random(seed);
		e = 32'hffffffff;
		run(`FBP_OP_ERASE, 14'h0, 0, WD);
		run(`FBP_OP_PROG, 14'h5, d, WD);
		run(`FBP_OP_ERASE, 14'h200, 0, WD);
		run(`FBP_OP_DREAD, 14'h5, 0, RD | d);
		run(`FBP_OP_DREAD, 14'h0ff, 0, RD | e);
		run(`FBP_OP_FETCH, 14'h200 | ($random(seed) & 14'h0ff), 0, RD | e);
		marks(32'h1, 0);
		run(`FBP_OP_PROG, 14'h5, 0, DN);
		run(`FBP_OP_ERASE, 14'h0, 0, DN);
		run(`FBP_OP_DREAD, 14'h5, 0, RD | d);
		marks(0, 32'h1);
		run(`FBP_OP_FETCH, 14'h5, 0, RD | d);
		run(`FBP_OP_DREAD, 14'h5, 0, DN);
		run(`FBP_OP_PROG, 14'h5, 0, DN);
		run(`FBP_OP_DBGRD, 14'h1ff, 0, DN);
		run(`FBP_OP_DBGRD, 14'h200, 0, RD | e);
		marks(0, 0);
		run(`FBP_OP_DBGRD, 14'h5, 0, RD | d);
		repeat (4) @(posedge ref_clk);
		chk(q.size(), 35'h0);
		finish_test;
	end
endmodule
bind fbp_flash_prot fbp_asserts fbp_asserts_i (.ref_clk, .rst, .req, .op, .addr, .ro_mark,
	.xo_mark, .ready, .rvalid, .denied, .wdone);
